// ==== sdi_rsb_ctrl.sv ====
/*
  Rate select, lock and passthrough control of a multi-rate serial video
  reclocker, with an APB register slave for its control bits.
  Assumes the analog loop supplies divided oscillator ticks, a phase loop
  status, a harmonic lock flag and retimed data, all synchronous to pclk,
  and that the input mux already delivers the selected serial input.
*/
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "sdi_rsb_defs.svh"
module sdi_rsb_ctrl
  import sdi_rsb_pkg::*;
#(
  parameter int WIN = `SDI_WIN_TICKS
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Rate code pins, two-way
  input  wire logic [2:0]  rate_code_in,
  output logic [2:0]       rate_code_out,
  output logic             rate_code_oe_n,
  // Loop interface
  input  wire logic        xtal_ref_tick,
  input  wire logic        vco_div_tick,
  input  wire logic        phase_acquisition_loop_ok,
  input  wire logic        harmonic_lock,
  output logic [2:0]       divider_rate,
  // Serial data
  input  wire logic        serial_in,
  input  wire logic        retimed_in,
  output logic             serial_out,
  output logic             serial_out_valid,
  // Status pins
  output logic             lock_flag,
  output logic             definition_class_out,
  output logic             passthrough_active
);
  sdi_top_st_t q;
  sdi_top_st_t d;

  logic win_done;
  logic within_acq;
  logic beyond_loss;

  // Step to the next enabled code in ascending order, wrapping at the top.
  function automatic logic [2:0] next_rate(input logic [2:0] r,
                                           input logic       skip);
    logic [2:0] n;
    n = (r >= `SDI_RATE_HD) ? `SDI_RATE_143 : r + 3'h1;
    if (skip && n == `SDI_RATE_177)
      n = `SDI_RATE_270;
    return n;
  endfunction

  function automatic logic rate_valid(input logic [2:0] r);
    return r <= `SDI_RATE_HD;
  endfunction

  sdi_rsb_freq_cmp #(
    .WIN (WIN)
  ) u_cmp (
    .pclk          (pclk),
    .presetn       (presetn),
    .restart       (q.restart),
    .xtal_ref_tick (xtal_ref_tick),
    .vco_div_tick  (vco_div_tick),
    .win_done      (win_done),
    .within_acq    (within_acq),
    .beyond_loss   (beyond_loss)
  );

  always_comb begin
    logic       auto_m;
    logic       force_p;
    logic       unl_p;
    logic       skip;
    logic       mute_n;
    logic       lock_n;
    logic       verdict;
    logic       wr;
    logic       rd_hit;
    logic [31:0] rdat;
    auto_m = q.ctrl[`SDI_CTRL_MODE];
    force_p = q.ctrl[`SDI_CTRL_FORCE];
    unl_p = q.ctrl[`SDI_CTRL_UNLOCK];
    skip = q.ctrl[`SDI_CTRL_SKIP];
    mute_n = q.ctrl[`SDI_CTRL_MUTE_N];
    lock_n = 1'b0;
    verdict = win_done && !q.restart;
    wr = 1'b0;
    rd_hit = 1'b0;
    rdat = 32'h0000_0000;
    d = q;

    // APB: the answer comes in the second access cycle.
    d.pready = psel && penable && !q.pready;
    d.pslverr = 1'b0;
    wr = psel && penable && q.pready && pwrite;
    if (wr && paddr == `SDI_OFS_CTRL)
      d.ctrl = pwdata[`SDI_CTRL_W-1:0];
    if (psel && penable && !q.pready) begin
      case (paddr)
        `SDI_OFS_CTRL: begin
          rd_hit = 1'b1;
          rdat[`SDI_CTRL_W-1:0] = q.ctrl;
        end
        `SDI_OFS_STATUS: begin
          rd_hit = !pwrite;
          rdat[`SDI_ST_LOCK] = q.lock;
          rdat[`SDI_ST_SHOWN_LO +: 3] = q.shown_rate;
          rdat[`SDI_ST_TRY_LO +: 3] = q.try_rate;
          rdat[`SDI_ST_CLASS] = q.dclass;
          rdat[`SDI_ST_PASS] = q.pass;
          rdat[`SDI_ST_PHASE] = (q.loop == SDI_PHASE_TRK);
          rdat[`SDI_ST_VALID] = q.svalid;
        end
        default: begin
          rd_hit = 1'b0;
        end
      endcase
      d.pslverr = !rd_hit;
      d.prdata = pwrite ? 32'h0000_0000 : rdat;
    end

    // Rate selection.
    if (auto_m) begin
      if (q.loop == SDI_FREQ_ACQ && verdict && !within_acq) begin
        d.try_rate = next_rate(q.try_rate, skip);
      end else if (!rate_valid(q.try_rate) ||
                   (skip && q.try_rate == `SDI_RATE_177)) begin
        d.try_rate = next_rate(q.try_rate, skip);
      end
    end else begin
      d.try_rate = rate_code_in;
    end

    // Loop state: frequency acquisition until the window agrees.
    case (q.loop)
      SDI_FREQ_ACQ: begin
        if (verdict && within_acq && !harmonic_lock &&
            rate_valid(q.try_rate) &&
            !(auto_m && skip && q.try_rate == `SDI_RATE_177))
          d.loop = SDI_PHASE_TRK;
      end
      SDI_PHASE_TRK: begin
        if ((verdict && beyond_loss) || harmonic_lock)
          d.loop = SDI_FREQ_ACQ;
        if (auto_m && skip && q.try_rate == `SDI_RATE_177)
          d.loop = SDI_FREQ_ACQ;
      end
      default: begin
        d.loop = SDI_FREQ_ACQ;
      end
    endcase
    if (d.try_rate != q.try_rate ||
        d.ctrl[`SDI_CTRL_MODE] != auto_m)
      d.loop = SDI_FREQ_ACQ;
    d.restart = (d.try_rate != q.try_rate) || (d.loop != q.loop);

    // Lock needs frequency agreement, phase lock and no harmonic.
    lock_n = (d.loop == SDI_PHASE_TRK) && phase_acquisition_loop_ok &&
             !harmonic_lock;
    d.lock = lock_n;
    if (lock_n)
      d.shown_rate = d.try_rate;
    d.oe_n = !d.ctrl[`SDI_CTRL_MODE];

    // Class follows the tried rate, so it toggles during the search.
    d.dclass = (d.try_rate != `SDI_RATE_HD);

    // Output path.
    d.pass = force_p || (unl_p && !lock_n);
    if (d.pass) begin
      d.sout = serial_in;
      d.svalid = 1'b1;
    end else if (lock_n) begin
      d.sout = mute_n ? retimed_in : 1'b0;
      d.svalid = 1'b1;
    end else begin
      d.sout = 1'b0;
      d.svalid = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.ctrl <= `SDI_CTRL_RST;
      q.loop <= SDI_FREQ_ACQ;
      q.try_rate <= `SDI_RATE_143;
      q.shown_rate <= `SDI_RATE_143;
      q.dclass <= 1'b1;
      q.oe_n <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign prdata = q.prdata;
  assign rate_code_out = q.shown_rate;
  assign rate_code_oe_n = q.oe_n;
  assign divider_rate = q.try_rate;
  assign serial_out = q.sout;
  assign serial_out_valid = q.svalid;
  assign lock_flag = q.lock;
  assign definition_class_out = q.dclass;
  assign passthrough_active = q.pass;
endmodule

// ==== sdi_rsb_defs.svh ====
/*
  Constants of the rate select and passthrough control block: register
  offsets, field positions, reset values, rate codes and window figures.
  Assumes it is included by bare name wherever these macros are needed.
*/
// How it works
// - Mode input high is auto, low manual.
// - Auto mode drives rate code showing locked rate.
// - Unlocked auto search steps rates, then wraps.
// - Unlocked auto class output follows tried rate.
// - Manual rate code is input; no search.
// - Rate codes 000 to 101, 143 to HD.
// - Passthrough routes serial input straight out.
// - Force passthrough holds passthrough regardless of lock.
// - Unlock passthrough only while not locked.
// - Force passthrough beats passthrough on unlock.
// - Unlocked without passthrough gives invalid output.
// - Skip input drops 177 rate in auto.
// - Lock flag high while locked, else low.
// - Lock combines both loops and harmonic detector.
// - Locked retiming with mute low mutes output.
// - Mute ignored while passthrough is active.
// - Frequency acquisition locks within one percent.
// - Phase tracking drops lock beyond two percent.
// - Timers count crystal reference ticks.
`ifndef SDI_RSB_DEFS_SVH
`define SDI_RSB_DEFS_SVH

`define SDI_OFS_CTRL      12'h000
`define SDI_OFS_STATUS    12'h004

`define SDI_CTRL_MODE     0
`define SDI_CTRL_FORCE    1
`define SDI_CTRL_UNLOCK   2
`define SDI_CTRL_SKIP     3
`define SDI_CTRL_MUTE_N   4
`define SDI_CTRL_W        5
`define SDI_CTRL_RST      5'h19

`define SDI_ST_LOCK       0
`define SDI_ST_SHOWN_LO   1
`define SDI_ST_TRY_LO     4
`define SDI_ST_CLASS      7
`define SDI_ST_PASS       8
`define SDI_ST_PHASE      9
`define SDI_ST_VALID      10

`define SDI_RATE_143      3'h0
`define SDI_RATE_177      3'h1
`define SDI_RATE_270      3'h2
`define SDI_RATE_360      3'h3
`define SDI_RATE_540      3'h4
`define SDI_RATE_HD       3'h5

`define SDI_CNT_W         16
`define SDI_WIN_TICKS     200
`define SDI_ACQ_PCT       1
`define SDI_LOSS_PCT      2

`endif

// ==== sdi_rsb_pkg.sv ====
/*
  Types of the rate select and passthrough control block.
  Assumes sdi_rsb_defs.svh is reachable by bare name.
*/
`include "sdi_rsb_defs.svh"
package sdi_rsb_pkg;
  typedef enum logic {SDI_FREQ_ACQ, SDI_PHASE_TRK} sdi_loop_t;

  typedef struct packed {
    logic [`SDI_CNT_W-1:0] xcnt;
    logic [`SDI_CNT_W-1:0] vcnt;
    logic                  done;
    logic                  acq;
    logic                  loss;
  } sdi_cmp_st_t;

  typedef struct packed {
    logic [`SDI_CTRL_W-1:0] ctrl;
    sdi_loop_t              loop;
    logic [2:0]             try_rate;
    logic [2:0]             shown_rate;
    logic                   restart;
    logic                   lock;
    logic                   pass;
    logic                   dclass;
    logic                   sout;
    logic                   svalid;
    logic                   oe_n;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
  } sdi_top_st_t;
endpackage

// ==== sdi_rsb_freq_cmp.sv ====
/*
  Frequency comparator: counts divided oscillator ticks over a window of
  crystal reference ticks and grades the difference.
  Assumes both tick inputs are one-cycle pulses synchronous to pclk.
*/
`timescale 1ns/1ps
`include "sdi_rsb_defs.svh"
module sdi_rsb_freq_cmp
  import sdi_rsb_pkg::*;
#(
  parameter int WIN = `SDI_WIN_TICKS
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Ticks and control
  input  wire logic restart,
  input  wire logic xtal_ref_tick,
  input  wire logic vco_div_tick,
  // Verdict
  output logic      win_done,
  output logic      within_acq,
  output logic      beyond_loss
);
  localparam logic [`SDI_CNT_W-1:0] WIN_C = `SDI_CNT_W'(WIN);
  localparam logic [`SDI_CNT_W-1:0] TOL_ACQ =
    `SDI_CNT_W'(WIN * `SDI_ACQ_PCT / 100);
  localparam logic [`SDI_CNT_W-1:0] TOL_LOSS =
    `SDI_CNT_W'(WIN * `SDI_LOSS_PCT / 100);

  initial begin
    if (WIN < 100 || WIN > 32000)
      $error("WIN must lie between 100 and 32000");
  end

  sdi_cmp_st_t q;
  sdi_cmp_st_t d;

  always_comb begin
    logic [`SDI_CNT_W-1:0] vc;
    logic [`SDI_CNT_W-1:0] diff;
    vc = q.vcnt;
    diff = '0;
    d = q;
    d.done = 1'b0;
    if (restart) begin
      d.xcnt = '0;
      d.vcnt = '0;
    end else begin
      if (vco_div_tick && q.vcnt != '1)
        vc = q.vcnt + `SDI_CNT_W'(1);
      d.vcnt = vc;
      // The window is timed by crystal ticks alone.
      if (xtal_ref_tick) begin
        if (q.xcnt == WIN_C - `SDI_CNT_W'(1)) begin
          diff = (vc > WIN_C) ? vc - WIN_C : WIN_C - vc;
          d.done = 1'b1;
          d.acq = (diff <= TOL_ACQ);
          d.loss = (diff > TOL_LOSS);
          d.xcnt = '0;
          d.vcnt = '0;
        end else begin
          d.xcnt = q.xcnt + `SDI_CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign win_done = q.done;
  assign within_acq = q.acq;
  assign beyond_loss = q.loss;
endmodule

// ==== sdi_rsb_chk.sv ====
/*
  Port checker of sdi_rsb_ctrl.
  Assumes it is bound onto every instance of that module.
*/
`timescale 1ns/1ps
`include "sdi_rsb_defs.svh"
module sdi_rsb_chk (
  // Clock and bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // Loop and data
  input wire logic        serial_in,
  input wire logic        harmonic_lock,
  input wire logic        phase_acquisition_loop_ok,
  input wire logic [2:0]  divider_rate,
  input wire logic [2:0]  rate_code_out,
  input wire logic        rate_code_oe_n,
  input wire logic        serial_out,
  input wire logic        serial_out_valid,
  input wire logic        lock_flag,
  input wire logic        definition_class_out,
  input wire logic        passthrough_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_pulse:
    assert property (pready |=> !pready) else $error("pready too long");
  a_err_map:
    assert property (pready && paddr != `SDI_OFS_CTRL
      && paddr != `SDI_OFS_STATUS |-> pslverr) else $error("no error");
  a_harm_unlock:
    assert property (harmonic_lock |=> !lock_flag) else $error("harmonic");
  a_phase_unlock:
    assert property (!phase_acquisition_loop_ok |=> !lock_flag)
      else $error("phase");
  a_locked_rate:
    assert property (lock_flag && $past(lock_flag) |->
      rate_code_out == divider_rate
      && definition_class_out == (divider_rate != 3'h5)) else $error("rate");
  a_search_step:
    assert property (!rate_code_oe_n && !lock_flag && $changed(divider_rate)
      |-> divider_rate == ($past(divider_rate) == 3'h5 ? 3'h0
      : $past(divider_rate) + 3'h1)
      || divider_rate == 3'h2 && $past(divider_rate) == 3'h0)
      else $error("search");
  a_pass_data:
    assert property (passthrough_active |->
      serial_out_valid && serial_out == $past(serial_in)) else $error("pass");
  a_class_follow:
    assert property (definition_class_out == (divider_rate != 3'h5))
      else $error("class");
  a_invalid_zero:
    assert property (!serial_out_valid |-> !serial_out) else $error("out");
endmodule

bind sdi_rsb_ctrl sdi_rsb_chk u_chk (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .serial_in(serial_in),
  .harmonic_lock(harmonic_lock),
  .phase_acquisition_loop_ok(phase_acquisition_loop_ok),
  .divider_rate(divider_rate), .rate_code_out(rate_code_out),
  .rate_code_oe_n(rate_code_oe_n), .serial_out(serial_out),
  .serial_out_valid(serial_out_valid), .lock_flag(lock_flag),
  .definition_class_out(definition_class_out),
  .passthrough_active(passthrough_active));

// ==== sdi_rsb_loop_model.sv ====
/*
  Loop side model: crystal and divided oscillator ticks and phase status.
  Assumes in_rate 110 or 111 stands for a signal at no supported rate.
*/
`timescale 1ns/1ps
module sdi_rsb_loop_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] divider_rate,
  input  wire logic [2:0] in_rate,
  input  wire logic       serial_in,
  output logic            xtal_ref_tick,
  output logic            vco_div_tick,
  output logic            phase_ok,
  output logic            retimed
);
  logic [1:0] xc_q;
  logic [2:0] vc_q;
  logic       match;
  // A wrong divider runs the oscillator 20 percent slow.
  assign match = divider_rate == in_rate;
  assign xtal_ref_tick = xc_q == 2'h3;
  assign vco_div_tick = vc_q == 3'h0;
  assign phase_ok = match;
  assign retimed = serial_in;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xc_q <= 2'h0;
      vc_q <= 3'h0;
    end else begin
      xc_q <= xc_q + 2'h1;
      vc_q <= (vc_q >= (match ? 3'h3 : 3'h4)) ? 3'h0 : vc_q + 3'h1;
    end
  end
endmodule

// ==== sdi_rsb_ctrl_tb.sv ====
/*
  Self-checking bench of sdi_rsb_ctrl.
  Assumes the loop model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
`include "sdi_rsb_defs.svh"
module sdi_rsb_ctrl_tb;
  logic        pclk = 1'b0, rn = 1'b0, sel = 1'b0, en = 1'b0, wr = 1'b0;
  logic        rdy, err, oe_n, xt, vt, pok, rt, harm = 1'b0;
  logic        sin = 1'b0, sout, sval, lock, dcls, pass;
  logic [11:0] adr = 12'h0;
  logic [31:0] wd = 32'h0, rd;
  logic [2:0]  rdrv = 3'h0, pins, rout, drate, in_r = 3'h0;
  logic [2:0]  rl[3] = '{3'h0, 3'h3, 3'h5};
  logic [32:0] exp_q[$];
  int          mismatches = 0, num_checks = 0, seed = 32'h2fc08acd;
  assign pins = oe_n ? rdrv : rout;
  always #20 pclk = ~pclk;
  always @(posedge pclk) sin <= $random(seed);
  sdi_rsb_ctrl #(.WIN(100)) dut (.pclk(pclk), .presetn(rn), .psel(sel),
    .penable(en), .pwrite(wr), .paddr(adr), .pwdata(wd), .pready(rdy),
    .pslverr(err), .prdata(rd), .rate_code_in(pins), .rate_code_out(rout),
    .rate_code_oe_n(oe_n), .xtal_ref_tick(xt), .vco_div_tick(vt),
    .phase_acquisition_loop_ok(pok), .harmonic_lock(harm),
    .divider_rate(drate), .serial_in(sin), .retimed_in(rt),
    .serial_out(sout), .serial_out_valid(sval), .lock_flag(lock),
    .definition_class_out(dcls), .passthrough_active(pass));
  sdi_rsb_loop_model lm (.pclk(pclk), .presetn(rn), .divider_rate(drate),
    .in_rate(in_r), .serial_in(sin), .xtal_ref_tick(xt),
    .vco_div_tick(vt), .phase_ok(pok), .retimed(rt));
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (!ok) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (sel && en && rdy === 1'b1) chk({err, rd} === exp_q.pop_front(), "apb");
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    sel <= 1'b1;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge pclk) en <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (n == 20) begin
      chk(1'b0, "apb hang");
      summarize();
    end
    sel <= 1'b0;
    en <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_lock(input logic want, input int lim);
    int n;
    n = 0;
    while (lock !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(lock === want, "lock");
    if (want && n == lim) summarize();
  endtask
  task automatic rst(input logic [2:0] r);
    in_r <= r;
    rn <= 1'b0;
    repeat (6) @(posedge pclk);
    rn <= 1'b1;
    @(posedge pclk);
  endtask
  function automatic logic [32:0] st(input logic [2:0] r);
    return {22'h0, 1'b1, 1'b1, 1'b0, r != 3'h5, r, r, 1'b1};
  endfunction
  initial begin
    rst(3'h1);
    apb(1'b0, `SDI_OFS_CTRL, 32'h0, 33'h19);
    apb(1'b0, 12'h008, 32'h0, 33'h100000000);
    apb(1'b1, `SDI_OFS_STATUS, 32'hffffffff, 33'h100000000);
    chk(sval === 1'b0, "invalid");
    wait_lock(1'b0, 3000);
    apb(1'b1, `SDI_OFS_CTRL, 32'h11, 33'h0);
    wait_lock(1'b1, 4000);
    foreach (rl[i]) begin
      rst(rl[i]);
      wait_lock(1'b1, 4000);
      chk(rout === rl[i] && oe_n === 1'b0, "rate");
      chk(dcls === (rl[i] != 3'h5), "class");
      apb(1'b0, `SDI_OFS_STATUS, 32'h0, st(rl[i]));
    end
    apb(1'b1, `SDI_OFS_CTRL, 32'h09, 33'h0);
    repeat (8) begin
      @(posedge pclk);
      chk(sout === 1'b0 && lock === 1'b1, "mute");
    end
    apb(1'b1, `SDI_OFS_CTRL, 32'h0b, 33'h0);
    repeat (2) @(posedge pclk);
    chk(pass === 1'b1 && lock === 1'b1, "force");
    harm <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(lock === 1'b0 && pass === 1'b1, "harmonic");
    harm <= 1'b0;
    rst(3'h0);
    apb(1'b1, `SDI_OFS_CTRL, 32'h1d, 33'h0);
    @(posedge pclk);
    chk(pass === 1'b1, "unlocked pass");
    wait_lock(1'b1, 2000);
    repeat (2) @(posedge pclk);
    chk(pass === 1'b0 && sval === 1'b1, "retime");
    rst(3'h2);
    rdrv <= 3'h1;
    apb(1'b1, `SDI_OFS_CTRL, 32'h18, 33'h0);
    wait_lock(1'b0, 2000);
    rdrv <= 3'h2;
    wait_lock(1'b1, 2000);
    chk(oe_n === 1'b1, "manual pins");
    summarize();
  end
endmodule
